// File: verilog/clock_monitor_and_mode_regs.v
// register slice: clock detection status, bit clock ratio, forced high-z and dsp program
//
// Behaviour
// - the low eight bits of the measured bit clocks per frame read back as a read-only byte.
// - in automatic rate mode status bit 0 shows whether the detected sample rate is valid.
// - with a fixed rate configured status bit 0 flags an error when it differs from the detected rate.
// - the rate error flag is raised even when rate errors are set to be ignored.
// - status bit 1 shows the bit clock valid only when its ratio is stable and within 32 to 512.
// - status bit 2 shows that the bit clock is missing.
// - status bit 3 shows pll lock and reads unlocked while the pll is disabled.
// - status bit 4 shows the pll running above its allowed rate.
// - status bit 5 shows the bit clock faster or slower than allowed.
// - writing 1 to control bit 3 forces the left channel to high impedance.
// - clearing a force bit hands the channel back to the channel state control.
// - writing 1 to control bit 2 forces the right channel to high impedance, 0 releases it.
// - a forced channel is released by a software write of 0 to its force bit or by reset.
// - the force bits have no effect while outputs are paralleled.
// - a two-bit program selector resetting to 01 picks ram or rom program one to three.
// - the top two ratio bits read in a separate read-only field forming the full count.
`timescale 1ns/100ps
`default_nettype none
`include "clock_monitor_map.vh"
module clock_monitor_and_mode_regs (
  // clock and reset
  input  wire       clock,
  input  wire       reset,
  // register port
  input  wire [7:0] regAddress,
  input  wire       regWrite,
  input  wire       regRead,
  input  wire [7:0] regWriteData,
  output reg  [7:0] regReadData,
  // detector inputs
  input  wire [3:0] configuredRate,
  input  wire [3:0] detectedRate,
  input  wire       detectedRateValid,
  input  wire [9:0] sclkRatio,
  input  wire       sclkRatioStable,
  input  wire       sclkMissing,
  input  wire       pllEnable,
  input  wire       pllLocked,
  input  wire       pllOverrate,
  input  wire       sclkOutOfRange,
  // channel control
  input  wire       paralleledBridgeOutput,
  input  wire       normalLeftHighz,
  input  wire       normalRightHighz,
  output wire       leftHighz,
  output wire       rightHighz,
  // dsp program
  output wire [1:0] dspProgram,
  output wire       programFromRam
);
  // live flags and captured copies
  wire [5:0] liveFlags;
  reg  [5:0] clockCheckFlags;
  reg  [9:0] ratio;
  reg  [1:0] flagsReserved;
  // program and high-z control register
  reg  [3:0] programReserved;
  reg        forceLeftHighz;
  reg        forceRightHighz;
  reg  [1:0] programSelect;
  reg  [7:0] next_readData;

  clock_flag_builder flagBuilder (
    .configuredRate    (configuredRate),
    .detectedRate      (detectedRate),
    .detectedRateValid (detectedRateValid),
    .sclkRatio         (sclkRatio),
    .sclkRatioStable   (sclkRatioStable),
    .sclkMissing       (sclkMissing),
    .pllEnable         (pllEnable),
    .pllLocked         (pllLocked),
    .pllOverrate       (pllOverrate),
    .sclkOutOfRange    (sclkOutOfRange),
    .flags             (liveFlags)
  );

  // status and ratio follow detector every cycle, untouched by reads or writes
  always @(posedge clock) begin
    if (reset) begin
      clockCheckFlags <= `RESET_FLAGS;
      ratio           <= `RESET_RATIO;
    end else begin
      clockCheckFlags <= liveFlags;
      ratio           <= sclkRatio;
    end
  end

  // writable fields; only reset or a software write changes the force bits
  always @(posedge clock) begin
    if (reset) begin
      flagsReserved   <= `RESERVED_FLAGS_RESET;
      programReserved <= `RESERVED_PGM_RESET;
      forceLeftHighz  <= 1'b0;
      forceRightHighz <= 1'b0;
      programSelect   <= `RESET_PROGRAM;
    end else if (regWrite) begin
      if (regAddress == `ADDR_CLOCK_FLAGS) begin
        flagsReserved <= regWriteData[7:6];
      end
      if (regAddress == `ADDR_PROGRAM_HIGHZ) begin
        programReserved <= regWriteData[7:4];
        forceLeftHighz  <= regWriteData[`FIELD_LEFT_HIGHZ];
        forceRightHighz <= regWriteData[`FIELD_RIGHT_HIGHZ];
        programSelect   <= regWriteData[1:0];
      end
    end
  end

  // read data mux
  always @* begin
    next_readData = 8'h00;
    case (regAddress)
      `ADDR_RATE_MONITOR:  next_readData = {2'h0, ratio[9:8], 4'h0};
      `ADDR_RATIO_LOW:     next_readData = ratio[7:0];
      `ADDR_CLOCK_FLAGS:   next_readData = {flagsReserved, clockCheckFlags};
      `ADDR_PROGRAM_HIGHZ: next_readData = {programReserved, forceLeftHighz, forceRightHighz, programSelect};
      default:             next_readData = 8'h00;
    endcase
  end

  // registered read data, loaded on a read strobe
  always @(posedge clock) begin
    if (reset) begin
      regReadData <= 8'h00;
    end else if (regRead) begin
      regReadData <= next_readData;
    end
  end

  // per-channel output state
  highz_force_gate leftGate (
    .forceBit         (forceLeftHighz),
    .paralleledBridge (paralleledBridgeOutput),
    .normalHighz      (normalLeftHighz),
    .channelHighz     (leftHighz)
  );

  highz_force_gate rightGate (
    .forceBit         (forceRightHighz),
    .paralleledBridge (paralleledBridgeOutput),
    .normalHighz      (normalRightHighz),
    .channelHighz     (rightHighz)
  );

  // program selection outputs
  assign dspProgram     = programSelect;
  assign programFromRam = (programSelect == `PROGRAM_RAM);
endmodule
`default_nettype wire

// File: include/clock_monitor_map.vh
// register offsets, field positions and reset values of the clock monitor slice
`ifndef CLOCK_MONITOR_MAP_VH
`define CLOCK_MONITOR_MAP_VH
`define ADDR_RATE_MONITOR      8'h37
`define ADDR_RATIO_LOW         8'h38
`define ADDR_CLOCK_FLAGS       8'h39
`define ADDR_PROGRAM_HIGHZ     8'h40
`define RESET_CLOCK_FLAGS      8'h00
`define RESET_PROGRAM_HIGHZ    8'h01
`define RESET_RATIO            10'h000
`define RESET_FLAGS            6'h00
`define RESET_PROGRAM          2'h1
`define RESERVED_FLAGS_RESET   2'h0
`define RESERVED_PGM_RESET     4'h0
`define FLAG_RATE              0
`define FLAG_SCLK_VALID        1
`define FLAG_SCLK_MISSING      2
`define FLAG_PLL_LOCK          3
`define FLAG_PLL_OVERRATE      4
`define FLAG_SCLK_RANGE        5
`define FIELD_LEFT_HIGHZ       3
`define FIELD_RIGHT_HIGHZ      2
`define RATIO_MIN              10'h020
`define RATIO_MAX              10'h200
`define RATE_AUTO              4'h0
`define PROGRAM_RAM            2'h0
`define PROGRAM_ROM1           2'h1
`define PROGRAM_ROM2           2'h2
`define PROGRAM_ROM3           2'h3
`endif

// File: verilog/clock_flag_builder.v
// assembles the six clock detection flags from detector levels
`timescale 1ns/100ps
`default_nettype none
`include "clock_monitor_map.vh"
module clock_flag_builder (
  // detector levels
  input  wire [3:0] configuredRate,
  input  wire [3:0] detectedRate,
  input  wire       detectedRateValid,
  input  wire [9:0] sclkRatio,
  input  wire       sclkRatioStable,
  input  wire       sclkMissing,
  input  wire       pllEnable,
  input  wire       pllLocked,
  input  wire       pllOverrate,
  input  wire       sclkOutOfRange,
  // assembled flags
  output wire [5:0] flags
);
  wire autoMode;
  wire ratioInSpan;
  assign autoMode    = (configuredRate == `RATE_AUTO);
  assign ratioInSpan = (sclkRatio >= `RATIO_MIN) && (sclkRatio <= `RATIO_MAX);
  // rate flag: validity in auto mode, mismatch error otherwise; ignore option not consulted
  assign flags[`FLAG_RATE] = autoMode ? detectedRateValid
                                      : (configuredRate != detectedRate);
  assign flags[`FLAG_SCLK_VALID]   = sclkRatioStable & ratioInSpan;
  assign flags[`FLAG_SCLK_MISSING] = sclkMissing;
  assign flags[`FLAG_PLL_LOCK]     = pllEnable & pllLocked;
  assign flags[`FLAG_PLL_OVERRATE] = pllOverrate;
  assign flags[`FLAG_SCLK_RANGE]   = sclkOutOfRange;
endmodule
`default_nettype wire

// File: verilog/highz_force_gate.v
// combines one channel's forced high-impedance bit with its normal state control
`timescale 1ns/100ps
`default_nettype none
module highz_force_gate (
  // controls
  input  wire forceBit,
  input  wire paralleledBridge,
  input  wire normalHighz,
  // result
  output wire channelHighz
);
  // force wins unless outputs are paralleled; cleared force hands back to normal control
  assign channelHighz = (forceBit & ~paralleledBridge) | normalHighz;
endmodule
`default_nettype wire

// File: verification/clock_monitor_and_mode_regs_properties.sv
// concurrent checks on the clock monitor register slice
`timescale 1ns/100ps
`default_nettype none
module clock_monitor_and_mode_regs_checker (
  // clock, reset and register port
  input wire logic clock, reset, regWrite, regRead,
  input wire logic [7:0] regAddress, regWriteData, regReadData,
  // detector and channel signals
  input wire logic [9:0] sclkRatio,
  input wire logic paralleledBridgeOutput, normalLeftHighz, normalRightHighz,
  input wire logic leftHighz, rightHighz, programFromRam,
  input wire logic [1:0] dspProgram
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // decoded requests
  wire rdLow = regRead && regAddress == 8'h38;
  wire rdHigh = regRead && regAddress == 8'h37;
  wire wrMode = regWrite && regAddress == 8'h40;
  property p_ratio_low; rdLow && !$past(reset) |=> regReadData == $past(sclkRatio[7:0], 2); endproperty
  a_ratio_low: assert property (p_ratio_low) else $error("ratio low byte wrong");
  property p_ratio_high; rdHigh && !$past(reset) |=> regReadData[5:4] == $past(sclkRatio[9:8], 2); endproperty
  a_ratio_high: assert property (p_ratio_high) else $error("ratio high bits wrong");
  property p_left_force; wrMode && regWriteData[3] ##1 !paralleledBridgeOutput |-> leftHighz; endproperty
  a_left_force: assert property (p_left_force) else $error("left not forced");
  property p_right_force; wrMode && regWriteData[2] ##1 !paralleledBridgeOutput |-> rightHighz; endproperty
  a_right_force: assert property (p_right_force) else $error("right not forced");
  property p_release; wrMode && regWriteData[3:2] == 2'h0 |=> leftHighz == normalLeftHighz && rightHighz == normalRightHighz; endproperty
  a_release: assert property (p_release) else $error("release wrong");
  property p_bridge; paralleledBridgeOutput |-> leftHighz == normalLeftHighz && rightHighz == normalRightHighz; endproperty
  a_bridge: assert property (p_bridge) else $error("force acts in bridge mode");
  property p_program; wrMode |=> dspProgram == $past(regWriteData[1:0]); endproperty
  a_program: assert property (p_program) else $error("program not stored");
  property p_ram; programFromRam == (dspProgram == 2'h0); endproperty
  a_ram: assert property (p_ram) else $error("ram select wrong");
  // main scenarios reached
  cover property (wrMode && regWriteData[3]);
  cover property (rdLow);
  cover property (paralleledBridgeOutput && leftHighz);
endmodule
bind clock_monitor_and_mode_regs clock_monitor_and_mode_regs_checker u_clock_monitor_and_mode_regs_checker (
  .clock, .reset, .regWrite, .regRead, .regAddress, .regWriteData, .regReadData, .sclkRatio,
  .paralleledBridgeOutput, .normalLeftHighz, .normalRightHighz, .leftHighz, .rightHighz,
  .programFromRam, .dspProgram);
`default_nettype wire

// File: verification/test_clock_monitor_and_mode_regs.sv
// self-checking bench for the clock monitor register slice
`timescale 1ns/100ps
`default_nettype none
module test_clock_monitor_and_mode_regs;
  // stimulus and observed signals
  logic clock = 0, reset = 1, regWrite = 0, regRead = 0, stable = 0, par = 0;
  logic [7:0] regAddress = 8'h00, regWriteData = 8'h00, regReadData, q;
  logic [9:0] ratio = 10'h000;
  logic [13:0] stim = 14'h0000;
  logic [1:0] normHz = 2'h0, dspProgram;
  logic leftHighz, rightHighz, programFromRam;
  logic [10:0] rt[6] = '{11'h41F, 11'h420, 11'h600, 11'h601, 11'h7A5, 11'h100};
  logic [0:5] rv = 6'b011000;
  logic [13:0] rows[9] = '{14'h0020, 14'h1560, 14'h1580, 14'h0010, 14'h0004, 14'h000C, 14'h0002, 14'h0001, 14'h003F};
  logic [5:0] fx[9] = '{6'h01, 6'h00, 6'h01, 6'h04, 6'h00, 6'h08, 6'h10, 6'h20, 6'h3D};
  int checks = 0, num_errors = 0, i;
  always #2 clock = ~clock;
  clock_monitor_and_mode_regs u_clock_monitor_and_mode_regs (.clock(clock), .reset(reset),
    .regAddress(regAddress), .regWrite(regWrite), .regRead(regRead), .regWriteData(regWriteData),
    .regReadData(regReadData), .configuredRate(stim[13:10]), .detectedRate(stim[9:6]),
    .detectedRateValid(stim[5]), .sclkRatio(ratio), .sclkRatioStable(stable), .sclkMissing(stim[4]),
    .pllEnable(stim[3]), .pllLocked(stim[2]), .pllOverrate(stim[1]), .sclkOutOfRange(stim[0]),
    .paralleledBridgeOutput(par), .normalLeftHighz(normHz[1]), .normalRightHighz(normHz[0]),
    .leftHighz(leftHighz), .rightHighz(rightHighz), .dspProgram(dspProgram), .programFromRam(programFromRam));
  // register write, effect settled on return
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock);
    regAddress <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    #1;
  endtask
  // register read into q
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    regAddress <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 q = regReadData;
  endtask
  task automatic chk(input string n, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    rd(8'h40);
    chk("mode reset", 8'h01, q);
    foreach (rt[k]) begin
      @(posedge clock);
      {stable, ratio} <= rt[k];
      rd(8'h38);
      chk("ratio low", rt[k][7:0], q);
      rd(8'h37);
      chk("ratio high", {2'h0, rt[k][9:8], 4'h0}, q);
      rd(8'h39);
      chk("sclk valid", {6'h00, rv[k], 1'b0}, q);
    end
    foreach (rows[k]) begin
      @(posedge clock);
      stim <= rows[k];
      rd(8'h39);
      chk("flags", {2'h0, fx[k]}, q);
    end
    rd(8'h39);
    chk("flags reread", 8'h3D, q);
    wr(8'h39, 8'hFF);
    wr(8'h38, 8'hFF);
    wr(8'h55, 8'hAA);
    rd(8'h39);
    chk("flags written", 8'hFD, q);
    rd(8'h38);
    chk("ratio written", 8'h00, q);
    rd(8'h55);
    chk("unmapped", 8'h00, q);
    for (i = 0; i < 4; i++) begin
      wr(8'h40, {4'h0, i[1:0], i[1:0]});
      chk("hz program", {3'h0, i[1:0], i == 0, i[1:0]}, {3'h0, leftHighz, rightHighz, programFromRam, dspProgram});
    end
    rd(8'h40);
    chk("mode readback", 8'h0F, q);
    wr(8'h39, 8'h00);
    chk("hz held", 8'h03, {6'h00, leftHighz, rightHighz});
    @(posedge clock);
    par <= 1'b1;
    normHz <= 2'h2;
    #1 chk("hz bridge", 8'h02, {6'h00, leftHighz, rightHighz});
    @(posedge clock);
    par <= 1'b0;
    wr(8'h40, 8'h01);
    chk("hz release", 8'h02, {6'h00, leftHighz, rightHighz});
    end_sim;
  end
  // watchdog against a hung sequence
  initial begin
    #20000;
    num_errors++;
    end_sim;
  end
endmodule
`default_nettype wire
